// ### codec_power_bias_pad_regs.v
// Behaviour
// - playback power bit 3 powers modulator 1, bit 2 modulator 0; 1 is up.
// - playback power bit 1 powers interpolator 1, bit 0 interpolator 0; 1 is up.
// - playback power bits 7:4 reserved, reset zero, read/write, no function.
// - bias A bits 7:6 headphone level: 00 normal,01 extreme save,10 enhanced,11 save.
// - bias A bits 5:4 front-end pair A level, same four codes as headphone.
// - bias A bits 3:2 converter pair B level; code 01 reserved.
// - bias A bits 1:0 converter pair A level; code 01 reserved.
// - bias B bit 6 set powers central bias down; bit 7 reserved, reset zero.
// - bias B bits 5:4 front-end pair B level, four codes as headphone.
// - bias B bits 3:2 microphone input bias level, four codes as headphone.
// - bias B bits 1:0 output converter level: normal, save, superior, enhanced.
// - both bias registers reset to zero: normal levels, central bias powered.
// - pull-up bits 6 and 5 disable the two microphone pin pair pull-ups.
// - pull-up bits 4..0 disable frame, bit clock, record 1, record 0, playback.
// - pull-up register resets to 7f, every listed pull-up disabled.
`timescale 1ns/10ps
`include "codec_power_bias_pad_regs.vh"

module codec_power_bias_pad_regs (
   // clock and reset
   input  wire                   i_clk_sys,
   input  wire                   i_srst,
   // control port register access
   input  wire [`CPB_ADDR_W-1:0] i_reg_addr,
   input  wire                   i_reg_wr,
   input  wire [`CPB_DATA_W-1:0] i_reg_wdata,
   input  wire                   i_reg_rd,
   output reg  [`CPB_DATA_W-1:0] o_reg_rdata,
   output reg                    o_reg_rvalid,
   output reg                    o_reg_hit,
   // playback path power enables
   output wire                   o_modulator1_power,
   output wire                   o_modulator0_power,
   output wire                   o_interp1_power,
   output wire                   o_interp0_power,
   // analog bias level selectors
   output wire [1:0]             o_headphone_bias_level,
   output wire [1:0]             o_frontend_pair_a_bias_level,
   output wire [1:0]             o_converter_pair_b_bias_level,
   output wire [1:0]             o_converter_pair_a_bias_level,
   output wire                   o_central_bias_off,
   output wire [1:0]             o_frontend_pair_b_bias_level,
   output wire [1:0]             o_mic_input_bias_level,
   output wire [1:0]             o_output_converter_bias_level,
   // pin pull-up disables, 1 means pull-up off
   output wire                   o_dmic_pair_b_pullup_off,
   output wire                   o_dmic_pair_a_pullup_off,
   output wire                   o_frame_clock_pullup_off,
   output wire                   o_bit_clock_pullup_off,
   output wire                   o_record_data1_pullup_off,
   output wire                   o_record_data0_pullup_off,
   output wire                   o_playback_data_pullup_off,
   // status
   output reg                    o_conv_bias_reserved
);

   // address match, used for every write strobe and for the read hit;
   // an exact compare on all eight bits, so the bank has no aliases
   // and a stray offset can never reach one of these registers
   function addr_is;
      input [`CPB_ADDR_W-1:0] addr;
      input [`CPB_ADDR_W-1:0] ofs;
      begin
         addr_is = (addr == ofs);
      end
   endfunction

   // converter selectors have no defined meaning for code 01;
   // the front-end, headphone and microphone selectors use 01 for
   // their lowest bias level, so this check is for converters only
   // and is kept as a function since both converter fields need it
   function conv_code_reserved;
      input [1:0] code;
      begin
         conv_code_reserved = (code == `CPB_BIAS_CONV_RESERVED);
      end
   endfunction

   // stored register values, each a full byte held in its own
   // instance; the reserved bits live in the same flops as the rest
   // and the field outputs below are plain wires off these flops
   wire [`CPB_DATA_W-1:0] playback_path_power;
   wire [`CPB_DATA_W-1:0] analog_bias_select_a;
   wire [`CPB_DATA_W-1:0] analog_bias_select_b;
   wire [`CPB_DATA_W-1:0] pin_pullup_disable;

   // address decode
   // one select per register, one-hot by construction
   wire sel_playback;
   wire sel_bias_a;
   wire sel_bias_b;
   wire sel_pullup;
   wire sel_any;

   // write strobes
   // one per register, each qualified by the write strobe
   wire we_playback;
   wire we_bias_a;
   wire we_bias_b;
   wire we_pullup;

   // read path next values; the mux is pure logic and the answer is
   // registered, so a read returns the byte as it stood at the strobe
   reg  [`CPB_DATA_W-1:0] next_rdata;
   wire                   next_conv_bias_reserved;

   // decode the control port address once for reads and writes;
   // a read and a write may share the decode in one cycle, and
   // sel_any covers the whole bank and feeds only the read hit flag
   assign sel_playback = addr_is(i_reg_addr, `CPB_OFS_PLAYBACK_POWER);
   assign sel_bias_a   = addr_is(i_reg_addr, `CPB_OFS_BIAS_SELECT_A);
   assign sel_bias_b   = addr_is(i_reg_addr, `CPB_OFS_BIAS_SELECT_B);
   assign sel_pullup   = addr_is(i_reg_addr, `CPB_OFS_PULLUP_DISABLE);
   assign sel_any      = sel_playback | sel_bias_a | sel_bias_b | sel_pullup;

   // writes to unmapped offsets are simply dropped
   // no byte enables: every write replaces all eight bits, so firmware
   // must rewrite the neighbouring fields it wants to keep;
   // writes land at the strobe edge and the fields, plain wires off the flops, change at that same edge
   assign we_playback = i_reg_wr & sel_playback;
   assign we_bias_a   = i_reg_wr & sel_bias_a;
   assign we_bias_b   = i_reg_wr & sel_bias_b;
   assign we_pullup   = i_reg_wr & sel_pullup;

   // playback path power, enables default off
   // layout: 7:4 reserved, 3 modulator 1, 2 modulator 0,
   // 1 interpolator 1, 0 interpolator 0
   // nothing downstream is powered until firmware sets an enable
   cpb_byte_reg #(
      .RESET_VALUE (`CPB_RST_PLAYBACK_POWER)
   ) u_playback_path_power (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_we      (we_playback),
      .i_wdata   (i_reg_wdata),
      .o_value   (playback_path_power)
   );

   // first bias register, all selectors normal after reset
   // layout: 7:6 headphone, 5:4 front-end pair a,
   // 3:2 converter pair b, 1:0 converter pair a
   cpb_byte_reg #(
      .RESET_VALUE (`CPB_RST_BIAS_SELECT_A)
   ) u_analog_bias_select_a (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_we      (we_bias_a),
      .i_wdata   (i_reg_wdata),
      .o_value   (analog_bias_select_a)
   );

   // second bias register, central bias powered after reset
   // layout: 7 reserved, 6 central bias off, 5:4 front-end pair b,
   // 3:2 microphone input, 1:0 output converter
   // the central bit is an off control, so a zero reset keeps the shared bias running
   cpb_byte_reg #(
      .RESET_VALUE (`CPB_RST_BIAS_SELECT_B)
   ) u_analog_bias_select_b (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_we      (we_bias_b),
      .i_wdata   (i_reg_wdata),
      .o_value   (analog_bias_select_b)
   );

   // pull-up disables; pads start with every pull-up off
   // layout: 7 reserved, 6 and 5 microphone pin pairs, 4 frame clock,
   // 3 bit clock, 2 record data 1, 1 record data 0, 0 playback data
   // pull-ups stay off until firmware knows which pins would float
   cpb_byte_reg #(
      .RESET_VALUE (`CPB_RST_PULLUP_DISABLE)
   ) u_pin_pullup_disable (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_we      (we_pullup),
      .i_wdata   (i_reg_wdata),
      .o_value   (pin_pullup_disable)
   );

   // modulator enables, 1 powers the modulator up
   // the analog side sees the raw bit; power-up sequencing is up to firmware
   // modulator and interpolator bits are independent, with no interlock
   assign o_modulator1_power = playback_path_power[`CPB_PP_MOD1_BIT];
   assign o_modulator0_power = playback_path_power[`CPB_PP_MOD0_BIT];

   // interpolator enables, 1 powers the interpolator up
   assign o_interp1_power = playback_path_power[`CPB_PP_INT1_BIT];
   assign o_interp0_power = playback_path_power[`CPB_PP_INT0_BIT];

   // bits 7:4 are kept only so software sees its own value again;
   // reserved playback bits only read back; they reach no output,
   // so whatever software leaves there cannot change the analog side

   // first bias register fields, passed as raw codes to the analog side
   // headphone and front-end codes: 00 normal, 01 extreme saving,
   // 10 enhanced, 11 saving; converter pairs share the list except
   // that 01 has no meaning there and is only flagged, never remapped
   assign o_headphone_bias_level =
      analog_bias_select_a[`CPB_BA_HP_MSB:`CPB_BA_HP_LSB];
   assign o_frontend_pair_a_bias_level =
      analog_bias_select_a[`CPB_BA_FE_A_MSB:`CPB_BA_FE_A_LSB];
   assign o_converter_pair_b_bias_level =
      analog_bias_select_a[`CPB_BA_CONV_B_MSB:`CPB_BA_CONV_B_LSB];
   assign o_converter_pair_a_bias_level =
      analog_bias_select_a[`CPB_BA_CONV_A_MSB:`CPB_BA_CONV_A_LSB];

   // second bias register fields; bit 7 is stored but drives nothing
   // front-end pair b and microphone use the headphone code list;
   // central bias off at 1, so the reset value keeps it running
   assign o_central_bias_off =
      analog_bias_select_b[`CPB_BB_CBIAS_OFF_BIT];
   assign o_frontend_pair_b_bias_level =
      analog_bias_select_b[`CPB_BB_FE_B_MSB:`CPB_BB_FE_B_LSB];
   assign o_mic_input_bias_level =
      analog_bias_select_b[`CPB_BB_MIC_MSB:`CPB_BB_MIC_LSB];
   // output converter code order differs from the others: 10 is the top level
   // 00 normal, 01 saving, 10 superior, 11 enhanced
   assign o_output_converter_bias_level =
      analog_bias_select_b[`CPB_BB_DAC_MSB:`CPB_BB_DAC_LSB];

   // microphone pin pair pull-ups, 1 disables
   // both pins of a pair share one control bit; pair a is bit 5, pair b bit 6
   assign o_dmic_pair_b_pullup_off =
      pin_pullup_disable[`CPB_PU_DMIC_B_BIT];
   assign o_dmic_pair_a_pullup_off =
      pin_pullup_disable[`CPB_PU_DMIC_A_BIT];

   // serial port pin pull-ups, 1 disables
   // each bit is independent and only touches its own pin
   assign o_frame_clock_pullup_off =
      pin_pullup_disable[`CPB_PU_FRAME_CLK_BIT];
   assign o_bit_clock_pullup_off =
      pin_pullup_disable[`CPB_PU_BIT_CLK_BIT];
   assign o_record_data1_pullup_off =
      pin_pullup_disable[`CPB_PU_REC_DATA1_BIT];
   assign o_record_data0_pullup_off =
      pin_pullup_disable[`CPB_PU_REC_DATA0_BIT];
   assign o_playback_data_pullup_off =
      pin_pullup_disable[`CPB_PU_PLAY_DATA_BIT];

   // flag a converter selector left on its undefined code; the hardware
   // still passes the code through, the flag only lets firmware notice
   assign next_conv_bias_reserved =
      conv_code_reserved(analog_bias_select_a[`CPB_BA_CONV_B_MSB:`CPB_BA_CONV_B_LSB]) |
      conv_code_reserved(analog_bias_select_a[`CPB_BA_CONV_A_MSB:`CPB_BA_CONV_A_LSB]);

   // registered so the status output comes straight from a flop;
   // it lags the register by one cycle and clears once the code is gone
   // firmware should not leave 01 in a converter field: its bias is undefined
   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_conv_bias_reserved <= 1'b0;
      end else begin
         o_conv_bias_reserved <= next_conv_bias_reserved;
      end
   end

   // read mux: full bytes, reserved bits included, unmapped reads zero
   // the select lines come from one decode, so at most one item
   // matches and the order of the items carries no priority
   always @* begin
      next_rdata = `CPB_READ_UNMAPPED;
      case (1'b1)
         sel_playback: begin
            next_rdata = playback_path_power;
         end
         sel_bias_a: begin
            next_rdata = analog_bias_select_a;
         end
         sel_bias_b: begin
            next_rdata = analog_bias_select_b;
         end
         sel_pullup: begin
            next_rdata = pin_pullup_disable;
         end
         default: begin
            next_rdata = `CPB_READ_UNMAPPED;
         end
      endcase
   end

   // read answer one cycle after the strobe; data holds until the next read
   // so a slow serial shifter can pick it up at leisure;
   // a read and a write to one offset in the same cycle return the old
   // byte, since the mux looks at the register before the write lands
   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_reg_rdata  <= `CPB_READ_UNMAPPED;
         o_reg_rvalid <= 1'b0;
         o_reg_hit    <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
            o_reg_hit   <= sel_any;
         end
      end
   end

endmodule // codec_power_bias_pad_regs

// ### codec_power_bias_pad_regs.vh
`ifndef CODEC_POWER_BIAS_PAD_REGS_VH
`define CODEC_POWER_BIAS_PAD_REGS_VH

// control port geometry
`define CPB_ADDR_W                8
`define CPB_DATA_W                8

// register offsets on the control port
`define CPB_OFS_PLAYBACK_POWER    8'h45
`define CPB_OFS_BIAS_SELECT_A     8'h46
`define CPB_OFS_BIAS_SELECT_B     8'h47
`define CPB_OFS_PULLUP_DISABLE    8'h48

// reset values
`define CPB_RST_PLAYBACK_POWER    8'h00
`define CPB_RST_BIAS_SELECT_A     8'h00
`define CPB_RST_BIAS_SELECT_B     8'h00
`define CPB_RST_PULLUP_DISABLE    8'h7f
`define CPB_READ_UNMAPPED         8'h00

// playback_path_power fields
`define CPB_PP_RSVD_MSB           7
`define CPB_PP_RSVD_LSB           4
`define CPB_PP_MOD1_BIT           3
`define CPB_PP_MOD0_BIT           2
`define CPB_PP_INT1_BIT           1
`define CPB_PP_INT0_BIT           0

// analog_bias_select_a fields
`define CPB_BA_HP_MSB             7
`define CPB_BA_HP_LSB             6
`define CPB_BA_FE_A_MSB           5
`define CPB_BA_FE_A_LSB           4
`define CPB_BA_CONV_B_MSB         3
`define CPB_BA_CONV_B_LSB         2
`define CPB_BA_CONV_A_MSB         1
`define CPB_BA_CONV_A_LSB         0

// analog_bias_select_b fields
`define CPB_BB_RSVD_BIT           7
`define CPB_BB_CBIAS_OFF_BIT      6
`define CPB_BB_FE_B_MSB           5
`define CPB_BB_FE_B_LSB           4
`define CPB_BB_MIC_MSB            3
`define CPB_BB_MIC_LSB            2
`define CPB_BB_DAC_MSB            1
`define CPB_BB_DAC_LSB            0

// pin_pullup_disable fields
`define CPB_PU_RSVD_BIT           7
`define CPB_PU_DMIC_B_BIT         6
`define CPB_PU_DMIC_A_BIT         5
`define CPB_PU_FRAME_CLK_BIT      4
`define CPB_PU_BIT_CLK_BIT        3
`define CPB_PU_REC_DATA1_BIT      2
`define CPB_PU_REC_DATA0_BIT      1
`define CPB_PU_PLAY_DATA_BIT      0

// bias selector codes
`define CPB_BIAS_NORMAL           2'h0
`define CPB_BIAS_CONV_RESERVED    2'h1

`endif

// ### cpb_byte_reg.v
`timescale 1ns/10ps
`include "codec_power_bias_pad_regs.vh"

// one control byte with its own reset value
module cpb_byte_reg #(
   parameter [`CPB_DATA_W-1:0] RESET_VALUE = 8'h00
) (
   // clock and reset
   input  wire                   i_clk_sys,
   input  wire                   i_srst,
   // write side
   input  wire                   i_we,
   input  wire [`CPB_DATA_W-1:0] i_wdata,
   // stored value
   output reg  [`CPB_DATA_W-1:0] o_value
);

   // all bits stored, reserved ones included, so software reads back what it wrote
   always @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_value <= RESET_VALUE;
      end else if (i_we) begin
         o_value <= i_wdata;
      end
   end

endmodule // cpb_byte_reg

// ### cpb_regs_properties.sv
`timescale 1ns/10ps
module cpb_regs_checker (
   // clock, reset and access port
   input wire       i_clk_sys,
   input wire       i_srst,
   input wire [7:0] i_reg_addr,
   input wire       i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire       i_reg_rd,
   input wire [7:0] o_reg_rdata,
   input wire       o_reg_rvalid,
   input wire       o_reg_hit,
   // field outputs
   input wire       o_modulator1_power,
   input wire       o_modulator0_power,
   input wire       o_interp1_power,
   input wire       o_interp0_power,
   input wire [1:0] o_headphone_bias_level,
   input wire [1:0] o_frontend_pair_a_bias_level,
   input wire [1:0] o_converter_pair_b_bias_level,
   input wire [1:0] o_converter_pair_a_bias_level,
   input wire       o_central_bias_off,
   input wire [1:0] o_frontend_pair_b_bias_level,
   input wire [1:0] o_mic_input_bias_level,
   input wire [1:0] o_output_converter_bias_level,
   input wire       o_dmic_pair_b_pullup_off,
   input wire       o_dmic_pair_a_pullup_off,
   input wire       o_frame_clock_pullup_off,
   input wire       o_bit_clock_pullup_off,
   input wire       o_record_data1_pullup_off,
   input wire       o_record_data0_pullup_off,
   input wire       o_playback_data_pullup_off,
   input wire       o_conv_bias_reserved
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   // field outputs regrouped as register images
   wire [3:0] pp = {o_modulator1_power, o_modulator0_power, o_interp1_power, o_interp0_power};
   wire [7:0] ba = {o_headphone_bias_level, o_frontend_pair_a_bias_level,
                    o_converter_pair_b_bias_level, o_converter_pair_a_bias_level};
   wire [6:0] bb = {o_central_bias_off, o_frontend_pair_b_bias_level,
                    o_mic_input_bias_level, o_output_converter_bias_level};
   wire [6:0] pu = {o_dmic_pair_b_pullup_off, o_dmic_pair_a_pullup_off, o_frame_clock_pullup_off,
                    o_bit_clock_pullup_off, o_record_data1_pullup_off, o_record_data0_pullup_off,
                    o_playback_data_pullup_off};
   // access steps
   sequence s_wr(a);
      i_reg_wr && i_reg_addr == a;
   endsequence
   sequence s_rd(a);
      i_reg_rd && i_reg_addr == a;
   endsequence
   sequence s_rsvd_code;
      s_wr(8'h46) ##0 (i_reg_wdata[3:2] == 2'h1 || i_reg_wdata[1:0] == 2'h1);
   endsequence

   a_pp_write: assert property (s_wr(8'h45) |=> pp == $past(i_reg_wdata[3:0]))
      else $error("playback power fields wrong after write");
   a_bias_a_write: assert property (s_wr(8'h46) |=> ba == $past(i_reg_wdata))
      else $error("bias a fields wrong after write");
   a_bias_b_write: assert property (s_wr(8'h47) |=> bb == $past(i_reg_wdata[6:0]))
      else $error("bias b fields wrong after write");
   a_pullup_write: assert property (s_wr(8'h48) |=> pu == $past(i_reg_wdata[6:0]))
      else $error("pullup fields wrong after write");
   a_reset_values: assert property ($fell(i_srst) |-> pp == 4'h0 && ba == 8'h00 && bb == 7'h00 && pu == 7'h7f)
      else $error("field outputs not at reset values");
   a_bias_a_hold: assert property (!(i_reg_wr && i_reg_addr == 8'h46) |=> $stable(ba))
      else $error("bias a fields moved without a write");
   a_bias_a_read: assert property (s_rd(8'h46) |=> o_reg_rvalid && o_reg_hit && o_reg_rdata == $past(ba))
      else $error("bias a read data wrong");
   a_unmapped_read: assert property (i_reg_rd && (i_reg_addr < 8'h45 || i_reg_addr > 8'h48)
      |=> o_reg_rvalid && !o_reg_hit && o_reg_rdata == 8'h00)
      else $error("unmapped read answered wrongly");
   a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
      else $error("read valid without a read");
   a_rsvd_flag: assert property (s_rsvd_code |-> ##2 o_conv_bias_reserved)
      else $error("reserved converter code not flagged");
endmodule // cpb_regs_checker

bind codec_power_bias_pad_regs cpb_regs_checker chk_u (.i_clk_sys, .i_srst, .i_reg_addr, .i_reg_wr,
   .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_reg_hit, .o_modulator1_power,
   .o_modulator0_power, .o_interp1_power, .o_interp0_power, .o_headphone_bias_level,
   .o_frontend_pair_a_bias_level, .o_converter_pair_b_bias_level, .o_converter_pair_a_bias_level,
   .o_central_bias_off, .o_frontend_pair_b_bias_level, .o_mic_input_bias_level,
   .o_output_converter_bias_level, .o_dmic_pair_b_pullup_off, .o_dmic_pair_a_pullup_off,
   .o_frame_clock_pullup_off, .o_bit_clock_pullup_off, .o_record_data1_pullup_off,
   .o_record_data0_pullup_off, .o_playback_data_pullup_off, .o_conv_bias_reserved);

// ### codec_power_bias_pad_regs_tb.sv
`timescale 1ns/10ps
module codec_power_bias_pad_regs_tb;
   // stimulus and observed outputs
   reg        clk;
   reg        srst;
   reg  [7:0] addr;
   reg        wr;
   reg  [7:0] wdata;
   reg        rd;
   wire [7:0] rdata;
   wire       rvalid;
   wire       hit;
   wire [3:0] pp;
   wire [1:0] hp, fea, cvb, cva, feb, mic, dac;
   wire       cbias;
   wire [6:0] pu;
   wire       rsv;
   integer    err_count;
   integer    checks_done;

   codec_power_bias_pad_regs dut_u (.i_clk_sys(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_reg_hit(hit),
      .o_modulator1_power(pp[3]), .o_modulator0_power(pp[2]), .o_interp1_power(pp[1]),
      .o_interp0_power(pp[0]), .o_headphone_bias_level(hp), .o_frontend_pair_a_bias_level(fea),
      .o_converter_pair_b_bias_level(cvb), .o_converter_pair_a_bias_level(cva),
      .o_central_bias_off(cbias), .o_frontend_pair_b_bias_level(feb), .o_mic_input_bias_level(mic),
      .o_output_converter_bias_level(dac), .o_dmic_pair_b_pullup_off(pu[6]),
      .o_dmic_pair_a_pullup_off(pu[5]), .o_frame_clock_pullup_off(pu[4]), .o_bit_clock_pullup_off(pu[3]),
      .o_record_data1_pullup_off(pu[2]), .o_record_data0_pullup_off(pu[1]),
      .o_playback_data_pullup_off(pu[0]), .o_conv_bias_reserved(rsv));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // all drives land on the falling edge, away from the sampling edge;
   // an idle cycle first keeps back-to-back writes apart
   task wrb(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   // bounded wait for the read answer, then judge data and hit
   task rdchk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
      integer n;
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n = n + 1;
      end
      if (rvalid !== 1'b1) begin
         err_count = err_count + 1;
         complete_run;
      end
      check("read latency", n[7:0], 8'h00);
      check("read data", rdata, exp);
      check("read hit", {7'h0, hit}, {7'h0, exp_hit});
      @(negedge clk);
      check("valid pulse", {7'h0, rvalid}, 8'h00);
      check("data holds", rdata, exp);
   endtask

   // two rising edges in reset, then release on a falling edge
   task do_reset;
      srst = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
   endtask

   task test_reset;
      check("playback", {4'h0, pp}, 8'h00);
      check("bias a", {hp, fea, cvb, cva}, 8'h00);
      check("bias b", {1'b0, cbias, feb, mic, dac}, 8'h00);
      check("pullups", {1'b0, pu}, 8'h7f);
      rdchk(8'h45, 8'h00, 1'b1);
      rdchk(8'h46, 8'h00, 1'b1);
      rdchk(8'h47, 8'h00, 1'b1);
      rdchk(8'h48, 8'h7f, 1'b1);
      $display("test reset done");
   endtask

   task test_playback;
      integer i;
      for (i = 0; i < 4; i = i + 1) begin
         wrb(8'h45, 8'h01 << i);
         check("playback", {4'h0, pp}, 8'h01 << i);
      end
      wrb(8'h45, 8'ha5);
      check("playback", {4'h0, pp}, 8'h05);
      rdchk(8'h45, 8'ha5, 1'b1);
      $display("test playback done");
   endtask

   task test_bias;
      integer c;
      logic [1:0] k;
      for (c = 0; c < 4; c = c + 1) begin
         k = c[1:0];
         wrb(8'h46, {k, k, k, k});
         check("bias a", {hp, fea, cvb, cva}, {k, k, k, k});
         @(negedge clk);
         check("reserved flag", {7'h0, rsv}, {7'h0, k == 2'h1});
         wrb(8'h47, {k, k, k, k});
         check("bias b", {1'b0, cbias, feb, mic, dac}, {1'b0, k[0], k, k, k});
         rdchk(8'h47, {k, k, k, k}, 1'b1);
      end
      wrb(8'h46, 8'h04);
      @(negedge clk);
      check("reserved flag", {7'h0, rsv}, 8'h01);
      wrb(8'h46, 8'h81);
      @(negedge clk);
      check("reserved flag", {7'h0, rsv}, 8'h01);
      rdchk(8'h46, 8'h81, 1'b1);
      $display("test bias done");
   endtask

   task test_pullup;
      integer i;
      for (i = 0; i < 7; i = i + 1) begin
         wrb(8'h48, ~(8'h01 << i) & 8'h7f);
         check("pullups", {1'b0, pu}, ~(8'h01 << i) & 8'h7f);
      end
      wrb(8'h48, 8'h80);
      check("pullups", {1'b0, pu}, 8'h00);
      $display("test pullup done");
   endtask

   // unmapped offsets must leave every register alone
   task test_unmapped;
      wrb(8'h44, 8'hff);
      wrb(8'h49, 8'hff);
      rdchk(8'h44, 8'h00, 1'b0);
      rdchk(8'h49, 8'h00, 1'b0);
      rdchk(8'h48, 8'h80, 1'b1);
      addr = 8'h45;
      wdata = 8'h3c;
      wr = 1'b1;
      rd = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      check("read old value", rdata, 8'ha5);
      check("playback", {4'h0, pp}, 8'h0c);
      $display("test unmapped done");
   endtask

   initial begin
      err_count = 0;
      checks_done = 0;
      addr = 8'h00;
      wr = 1'b0;
      wdata = 8'h00;
      rd = 1'b0;
      do_reset;
      test_reset;
      test_playback;
      test_bias;
      test_pullup;
      test_unmapped;
      do_reset;
      test_reset;
      complete_run;
   end
endmodule // codec_power_bias_pad_regs_tb
